// ===== verilog/sac_pkg.sv
`default_nettype none
package sac_pkg;
  // Result format
  localparam int unsigned RES_BITS = 12;
  localparam logic [11:0] NEG_FULL_SCALE_CODE = 12'h000;
  localparam logic [11:0] MID_SCALE_CODE = 12'h800;
  localparam logic [11:0] POS_FULL_SCALE_CODE = 12'hfff;
  // Serial clock falling edge counts within a frame
  localparam logic [5:0] DATA_LAST_EDGE = 6'h0e;
  localparam logic [5:0] PWRUP_CAL_EDGES = 6'h10;
  localparam logic [5:0] CAL_START_EDGE = 6'h11;
  localparam logic [5:0] CAL_DONE_EDGE = 6'h20;
  localparam logic [5:0] EDGE_CNT_MAX = 6'h3f;
  // Least calibration length, serial clock periods
  localparam logic [5:0] CAL_MIN_PERIODS = 6'h0f;
  // Host-side timings, ns
  localparam int unsigned SELECT_TO_CLOCK_SETUP_NS = 15;
  localparam int unsigned ACQUISITION_INTERVAL_NS = 200;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ACQ_CYCLES =
    (ACQUISITION_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_DATA = 2'b01,
    SAC_QUIET = 2'b10,
    SAC_CAL = 2'b11
  } sac_state_t;

  // Serial output pin as value plus enable
  typedef struct packed {
    logic data;
    logic oe;
  } sac_sdo_t;
endpackage
`default_nettype wire

// ===== verilog/sac_top.sv
`timescale 1ns/10ps
`default_nettype none
module sac_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [11:0] sample_code_i,
  input wire logic [11:0] offset_measure_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic input_connect_o,
  output logic cal_active_o,
  output logic frame_active_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic cs_meta_r;
  logic cs_sync_r;
  logic cs_prev_r;
  logic ck_meta_r;
  logic ck_sync_r;
  logic ck_prev_r;
  logic cs_fall;
  logic cs_rise;
  logic ck_fall;

  // Select pin: three flops, only the second and third stages are looked at
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
    end
    else
    begin
      cs_meta_r <= cs_n_i;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
    end
  end

  // Link clock pin; a rise seen after reset is harmless, only falls count
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ck_meta_r <= 1'b0;
      ck_sync_r <= 1'b0;
      ck_prev_r <= 1'b0;
    end
    else
    begin
      ck_meta_r <= sclk_i;
      ck_sync_r <= ck_meta_r;
      ck_prev_r <= ck_sync_r;
    end
  end

  assign cs_fall = cs_prev_r & ~cs_sync_r;
  assign cs_rise = ~cs_prev_r & cs_sync_r;
  // Clock edges only count inside a frame
  assign ck_fall = ck_prev_r & ~ck_sync_r & ~cs_sync_r;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  sac_pkg::sac_state_t state_r;
  logic [5:0] edge_cnt_r;
  logic [5:0] edge_cnt_nxt;
  logic first_frame_r;
  logic pwrup_frame_r;

  // Saturate so very long frames do not wrap into the data window
  assign edge_cnt_nxt = (edge_cnt_r == sac_pkg::EDGE_CNT_MAX) ?
    edge_cnt_r : edge_cnt_r + 6'h01;

  // Falling edge count since the select fall
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      edge_cnt_r <= 6'h00;
    else if (cs_fall)
      edge_cnt_r <= 6'h00;
    else if (ck_fall)
      edge_cnt_r <= edge_cnt_nxt;
  end

  // Power-up flag; the first frame is the calibration frame
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      first_frame_r <= 1'b1;
      pwrup_frame_r <= 1'b0;
    end
    else if (cs_fall)
    begin
      pwrup_frame_r <= first_frame_r;
      first_frame_r <= 1'b0;
    end
    else if (cs_rise)
      pwrup_frame_r <= 1'b0;
  end

  // State follows the frame and the edge count
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_r <= sac_pkg::SAC_IDLE;
    else if (cs_rise)
      state_r <= sac_pkg::SAC_IDLE;
    else if (cs_fall)
      state_r <= first_frame_r ? sac_pkg::SAC_CAL : sac_pkg::SAC_DATA;
    else
    begin
      unique case (state_r)
        sac_pkg::SAC_IDLE:
          state_r <= sac_pkg::SAC_IDLE;
        sac_pkg::SAC_DATA:
          if (ck_fall && edge_cnt_nxt == sac_pkg::DATA_LAST_EDGE)
            state_r <= sac_pkg::SAC_QUIET;
        sac_pkg::SAC_QUIET:
          // A power-up frame has calibrated already and stays quiet
          if (ck_fall && !pwrup_frame_r &&
              edge_cnt_nxt == sac_pkg::CAL_START_EDGE)
            state_r <= sac_pkg::SAC_CAL;
        sac_pkg::SAC_CAL:
          if (ck_fall && !pwrup_frame_r &&
              edge_cnt_nxt == sac_pkg::CAL_DONE_EDGE)
            state_r <= sac_pkg::SAC_QUIET;
          else if (ck_fall && pwrup_frame_r &&
                   edge_cnt_nxt == sac_pkg::PWRUP_CAL_EDGES)
            state_r <= sac_pkg::SAC_QUIET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sample capture, offset correction and shift out
  // ----------------------------------------------------------------
  logic [11:0] offset_correction_store_r;
  logic [13:0] shift_r;
  logic sdo_r;
  logic sdo_oe_r;

  // Subtract the stored offset, clamping at both ends of the range
  function automatic logic [11:0] sac_correct(input logic [11:0] raw,
                                              input logic [11:0] ofs);
    logic signed [13:0] diff;
    diff = 14'(signed'({2'b00, raw})) - 14'(signed'({{2{ofs[11]}}, ofs}));
    if (diff < 0)
      sac_correct = sac_pkg::NEG_FULL_SCALE_CODE;
    else if (diff > 14'(sac_pkg::POS_FULL_SCALE_CODE))
      sac_correct = sac_pkg::POS_FULL_SCALE_CODE;
    else
      sac_correct = diff[11:0];
  endfunction

  // Capture at select fall; two zero bits lead the result
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      shift_r <= 14'h0000;
    else if (cs_fall)
      shift_r <= {2'b00,
        sac_correct(sample_code_i, offset_correction_store_r)};
    else if (ck_fall)
      shift_r <= {shift_r[12:0], 1'b0};
  end

  // Pin drive: first bit on select fall, low outside the data window
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end
    else if (cs_rise)
    begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end
    else if (cs_fall)
    begin
      sdo_oe_r <= 1'b1;
      sdo_r <= 1'b0;
    end
    else if (ck_fall)
    begin
      if (state_r == sac_pkg::SAC_DATA &&
          edge_cnt_nxt < sac_pkg::DATA_LAST_EDGE)
        sdo_r <= shift_r[12];
      else
        sdo_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Offset calibration
  // ----------------------------------------------------------------
  logic [5:0] cal_len_r;

  // Count calibration periods; the store only changes at completion
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cal_len_r <= 6'h00;
    else if (cs_fall)
      cal_len_r <= 6'h00;
    else if (ck_fall && state_r == sac_pkg::SAC_CAL)
      cal_len_r <= cal_len_r + 6'h01;
  end

  // Hidden store: no serial path reads or writes it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      offset_correction_store_r <= 12'h000;
    else if (ck_fall && state_r == sac_pkg::SAC_CAL &&
             cal_len_r + 6'h01 >= sac_pkg::CAL_MIN_PERIODS &&
             ((pwrup_frame_r &&
               edge_cnt_nxt == sac_pkg::PWRUP_CAL_EDGES) ||
              (!pwrup_frame_r &&
               edge_cnt_nxt == sac_pkg::CAL_DONE_EDGE)))
      offset_correction_store_r <= offset_measure_i;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic cal_r;
  logic frame_r;
  logic connect_r;

  // Calibration status trails the sequencer by one cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cal_r <= 1'b0;
    else
      cal_r <= (state_r == sac_pkg::SAC_CAL);
  end

  // Frame status, registered so the pin side sees no glitches
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      frame_r <= 1'b0;
    else
      frame_r <= (state_r != sac_pkg::SAC_IDLE);
  end

  // Inputs disconnected during conversion and calibration
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      connect_r <= 1'b1;
    else
      connect_r <= (state_r == sac_pkg::SAC_IDLE) ||
                   (state_r == sac_pkg::SAC_QUIET);
  end

  assign sdo_o = sdo_r;
  assign sdo_oe_o = sdo_oe_r;
  assign cal_active_o = cal_r;
  assign frame_active_o = frame_r;
  assign input_connect_o = connect_r;

endmodule
`default_nettype wire

// ===== verif/sac_host.sv
`timescale 1ns/10ps
`default_nettype none
module sac_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic cs_n_o,
  output logic sclk_o
);
  localparam realtime HALF_NS = 62.5;
  logic line;
  // Host pull-up: a released data line reads high, never a stale bit
  assign line = sdo_oe_i ? sdo_i : 1'b1;
  // Link clock stands high between frames
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
  end
  // One frame of n falls; bit k is read just before fall k+1
  task automatic frame(input int n, output logic [63:0] bits,
    output logic oe_after);
    bits = '0;
    @(posedge clk_i);
    #3;
    cs_n_o = 1'b0;
    for (int k = 0; k <= n; k++)
    begin
      #(HALF_NS);
      bits[k] = line;
      if (k < n)
      begin
        sclk_o = 1'b0;
        #(HALF_NS);
        sclk_o = 1'b1;
      end
    end
    cs_n_o = 1'b1;
    #(HALF_NS * 2);
    oe_after = sdo_oe_i;
    #(HALF_NS * 2);
  endtask
endmodule
`default_nettype wire

// ===== verif/sac_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sac_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [11:0] sample_code_i,
  input wire logic [11:0] offset_measure_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic input_connect_o,
  input wire logic cal_active_o,
  input wire logic frame_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic sclk_r, cs_r, first_r;
  logic [5:0] edge_r;
  // Pin-level count of clock falls in the frame; saturates
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_r <= 1'b1;
      cs_r <= 1'b1;
      edge_r <= 6'h00;
    end
    else
    begin
      sclk_r <= sclk_i;
      cs_r <= cs_n_i;
      if (cs_n_i)
        edge_r <= 6'h00;
      else if (sclk_r && !sclk_i && edge_r != 6'h3f)
        edge_r <= edge_r + 6'h01;
    end
  end
  // Marks the first frame after reset until select rises
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      first_r <= 1'b1;
    else if (cs_n_i && !cs_r)
      first_r <= 1'b0;
  end
  frame_start_a: assert property ($fell(cs_n_i) |-> ##[2:6]
    (sdo_oe_o && frame_active_o)) else $error("frame not opened");
  first_bit_a: assert property ($fell(cs_n_i) |-> ##[2:6]
    (sdo_oe_o && !sdo_o)) else $error("first bit not zero");
  tri_state_a: assert property ($rose(cs_n_i) |-> ##[1:6]
    !sdo_oe_o) else $error("output not released");
  quiet_low_a: assert property ((!cs_n_i && edge_r >= 6'h0f)
    |-> !sdo_o) else $error("data after bit fourteen");
  pwr_low_a: assert property ((first_r && !cs_n_i) |-> !sdo_o)
    else $error("data in first frame");
  cal_disc_a: assert property (cal_active_o |->
    !input_connect_o) else $error("inputs connected in cal");
  cal_late_a: assert property ((!first_r && !cs_n_i &&
    edge_r inside {[6'h02:6'h10]}) |-> !cal_active_o) else $error("cal early");
  cal_done_a: assert property ((!cs_n_i && edge_r >= 6'h21)
    |-> !cal_active_o) else $error("cal past edge 32");
endmodule
bind sac_top sac_checker i_chk (.clk_i, .rst_i, .cs_n_i, .sclk_i,
  .sample_code_i, .offset_measure_i, .sdo_o, .sdo_oe_o,
  .input_connect_o, .cal_active_o, .frame_active_o);
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n_i, sclk_i, oe_after;
  logic [11:0] sample_code_i = 12'h000;
  logic [11:0] offset_measure_i = 12'h000;
  logic sdo_o, sdo_oe_o, input_connect_o, cal_active_o, frame_active_o;
  logic [63:0] bits;
  int fails = 0;
  int checks = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  sac_top i_dut (.clk_i, .rst_i, .cs_n_i, .sclk_i, .sample_code_i,
    .offset_measure_i, .sdo_o, .sdo_oe_o, .input_connect_o,
    .cal_active_o, .frame_active_o);
  sac_host i_host (.clk_i, .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
    .cs_n_o(cs_n_i), .sclk_o(sclk_i));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Frame image: two zeros, result MSB first, zeros after
  task automatic frame_chk(input int n, input logic [11:0] code,
    input logic [11:0] ofs, input logic [11:0] res, input logic quiet);
    logic [63:0] img;
    img = '0;
    for (int k = 0; k < 12; k++)
      img[13-k] = quiet ? 1'b0 : res[k];
    @(posedge clk_i);
    sample_code_i <= code;
    offset_measure_i <= ofs;
    i_host.frame(n, bits, oe_after);
    chk(bits, img);
    chk({63'h0, oe_after}, 64'h0);
  endtask
  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Power-up cal, then correction with clamping at zero
  task automatic t_pwrup_cal;
    frame_chk(16, 12'h800, 12'h010, 12'h000, 1'b1);
    frame_chk(14, 12'h800, 12'h000, 12'h7f0, 1'b0);
    frame_chk(14, 12'h004, 12'h000, 12'h000, 1'b0);
    $display("test pwrup_cal done");
  endtask
  // A frame one fall short must leave the store alone
  task automatic t_short_cal;
    frame_chk(31, 12'hfff, 12'h020, 12'hfef, 1'b0);
    frame_chk(14, 12'hfff, 12'h000, 12'hfef, 1'b0);
    $display("test short_cal done");
  endtask
  // Full cal frame loads a negative offset; top clamps at fff
  task automatic t_normal_cal;
    frame_chk(34, 12'h800, 12'hffe, 12'h7f0, 1'b0);
    frame_chk(20, 12'h800, 12'h000, 12'h802, 1'b0);
    frame_chk(14, 12'hffe, 12'h000, 12'hfff, 1'b0);
    $display("test normal_cal done");
  endtask
  // Second reset clears store; short first frame stays quiet
  task automatic t_short_pwrup;
    do_reset;
    frame_chk(8, 12'h800, 12'h040, 12'h000, 1'b1);
    frame_chk(14, 12'h800, 12'h000, 12'h800, 1'b0);
    $display("test short_pwrup done");
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    do_reset;
    t_pwrup_cal;
    t_short_cal;
    t_normal_cal;
    t_short_pwrup;
    final_report;
  end
  // Watchdog: the run needs about 26 us
  initial
  begin
    #100us;
    fails++;
    final_report;
  end
endmodule
`default_nettype wire
